// File: rtl/flash_status_write_latch.v
// Status word, write latch and command decode of a serial multi-line flash
`timescale 1ns/1ps
`include "flash_sr_defs.vh"
module flash_status_write_latch #(
    parameter        TW_CYCLES  = `TW_CYCLES,
    parameter [7:0]  OP_QPROG   = 8'h32,
    parameter [7:0]  OP_SEC_ERS = 8'h44,
    parameter [7:0]  OP_SEC_PRG = 8'h42
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // Serial pins
    input  wire        cs_n_pin,
    input  wire        sclk_pin,
    input  wire        hard_reset_n_pin,
    input  wire [3:0]  io_in,
    output wire [3:0]  io_out,
    output wire [3:0]  io_oe,
    // Program/erase engine
    output reg         pe_start,
    output reg  [7:0]  pe_opcode,
    output reg  [23:0] pe_addr,
    output reg         pe_suspend,
    output reg         pe_resume,
    output reg         pe_abort,
    input  wire        pe_done,
    input  wire        pe_fail,
    input  wire        target_protected,
    // Block state
    output wire [15:0] status_word,
    output wire        quad_pins_data,
    output wire        four_line_mode
);
    //////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edges
    wire       cs_s;
    wire       sclk_s;
    wire       hrst_s;
    wire [3:0] io_s;
    reg        cs_d_r;
    reg        sclk_d_r;

    pin_sync #(.W(3), .RST_VAL(5)) u_ctl_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      ({cs_n_pin, sclk_pin, hard_reset_n_pin}),
        .q      ({cs_s, sclk_s, hrst_s})
    );
    pin_sync #(.W(4), .RST_VAL(15)) u_io_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      (io_in),
        .q      (io_s)
    );

    // Delayed copies for edge finding
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cs_d_r   <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            cs_d_r   <= cs_s;
            sclk_d_r <= sclk_s;
        end
    end
    wire cs_fall   = ~cs_s & cs_d_r;
    wire cs_rise   = cs_s & ~cs_d_r;
    wire sclk_rise = ~cs_s & sclk_s & ~sclk_d_r;
    wire sclk_fall = ~cs_s & ~sclk_s & sclk_d_r;

    //////////////////////////////////////////////////////////////////////
    // State
    reg [15:0] ctl_r;        // Active copy of writable bits
    reg [15:0] nv_r;         // Non-volatile copy
    reg        write_enable_latch_r;
    reg        vol_r;        // Volatile write armed
    reg        fail_r;
    reg        suspend_flag_r;
    reg        quad_r;       // Four-line command mode
    reg        rst_en_r;
    reg        pe_busy_r;
    reg [31:0] sh_r;
    reg [5:0]  cnt_r;
    reg [7:0]  op_r;
    reg [7:0]  d0_r;
    reg [7:0]  d1_r;
    reg [3:0]  so_r;

    wire       tw_busy;
    wire       tw_done;
    reg        tw_start;

    //////////////////////////////////////////////////////////////////////
    // Status word assembly
    // busy bit
    wire write_in_progress = tw_busy | (pe_busy_r & ~suspend_flag_r);
    assign status_word = {suspend_flag_r, ctl_r[14:11], fail_r, ctl_r[9:2],
                          write_enable_latch_r, write_in_progress};
    wire [4:0] bp_bits  = ctl_r[`SB_BP_HI:`SB_BP_LO];
    wire       cmp_bit  = ctl_r[`SB_CMP];
    wire       qe_bit   = ctl_r[`SB_QE];
    wire [1:0] srp_mode = {ctl_r[`SB_PROTECT_MODE_HIGH], ctl_r[`SB_PROTECT_MODE_LOW]};
    assign quad_pins_data = qe_bit;
    assign four_line_mode = quad_r;

    // register lock by mode and pin
    reg locked;
    always @* begin
        case (srp_mode)
            2'b00:   locked = 1'b0;
            // Pin is data while quad enabled, so it cannot lock
            2'b01:   locked = ~qe_bit & ~io_s[2];
            default: locked = 1'b1;
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Receive shifter
    // nibble per clock in four-line mode, IO3 as top bit
    wire [31:0] sh_nxt  = quad_r ? {sh_r[27:0], io_s} : {sh_r[30:0], io_s[0]};
    wire [5:0]  step    = quad_r ? 6'd4 : 6'd1;
    wire [5:0]  cnt_nxt = (cnt_r >= 6'd60) ? `CNT_SAT : cnt_r + step;

    // Security register select and lock check
    // address decode
    wire        sec_hi0 = (pe_addr[22:16] == 7'h00);
    wire [5:0]  sec_sel = pe_addr[15:10];
    reg         sec_locked;
    always @* begin
        sec_locked = 1'b1;   // Unknown area is refused
        if (sec_hi0 && sec_sel == `SEC_SEL1)
            sec_locked = ctl_r[`SB_LB1];
        else if (sec_hi0 && sec_sel == `SEC_SEL2)
            sec_locked = ctl_r[`SB_LB1+1];
        else if (sec_hi0 && sec_sel == `SEC_SEL3)
            sec_locked = ctl_r[`SB_LB3];
    end

    //////////////////////////////////////////////////////////////////////
    // Frame-end decode
    wire is_rd    = (op_r == `OP_RD_LO) || (op_r == `OP_RD_HI);
    wire [7:0] rd_byte = (op_r == `OP_RD_HI) ? status_word[15:8] : status_word[7:0];
    wire is_chip  = (op_r == `OP_CHIP_ERASE0) || (op_r == `OP_CHIP_ERASE1);
    wire is_sec   = (op_r == OP_SEC_ERS) || (op_r == OP_SEC_PRG);
    wire is_addr  = (op_r == `OP_PAGE_PROG) || (op_r == OP_QPROG) ||
                    (op_r == `OP_SECT_ERASE) || (op_r == `OP_HALF_ERASE) ||
                    (op_r == `OP_BLK_ERASE) || is_sec;
    wire busy_any = tw_busy | pe_busy_r;
    wire op_end   = cs_rise && cnt_r == `CNT_OP;
    wire soft_rst = (op_end && op_r == `OP_RST && rst_en_r) || ~hrst_s;
    wire wr_sr    = cs_rise && ((op_r == `OP_WR_SR &&
                    (cnt_r == `CNT_D0 || cnt_r == `CNT_D1)) ||
                    (op_r == `OP_WR_SRH && cnt_r == `CNT_D0));
    wire wr_cfg   = cs_rise && op_r == `OP_WR_CFG && cnt_r == `CNT_D0;
    // write needs latch or volatile arm
    wire wr_ok    = (write_enable_latch_r | vol_r) & ~locked & ~busy_any;
    wire pe_req   = cs_rise && ((is_addr && cnt_r == `CNT_ADDR) ||
                    (is_chip && cnt_r == `CNT_OP));
    wire pe_ok    = write_enable_latch_r & ~busy_any & ~suspend_flag_r;
    // chip erase only with nothing protected
    wire pe_prot  = is_chip ? (bp_bits != 5'd0 || cmp_bit) :
                    is_sec  ? sec_locked : target_protected;

    cycle_timer #(.CW(18)) u_tw (
        .mclk   (mclk),
        .resetn (resetn),
        .start  (tw_start),
        .abort  (soft_rst),
        .load   (TW_CYCLES[17:0]),
        .busy   (tw_busy),
        .done   (tw_done)
    );

    // New register value from written bytes
    // lock bits only ever set
    wire [15:0] wr_val = {ctl_r[15], d1_r[6], ctl_r[13:11] | d1_r[5:3],
                          ctl_r[10], d1_r[1:0], d0_r[7:2], ctl_r[1:0]};
    wire        two_b  = (op_r == `OP_WR_SR && cnt_r == `CNT_D1);
    wire        hi_b   = (op_r == `OP_WR_SRH) || two_b;
    wire [15:0] wr_new = {hi_b ? wr_val[15:8] : ctl_r[15:8],
                          (op_r == `OP_WR_SRH) ? ctl_r[7:0] : wr_val[7:0]};
    // 31H carries its byte first, so take it from the low capture
    wire [15:0] wr_sel = (op_r == `OP_WR_SRH) ?
                         {ctl_r[15], d0_r[6], ctl_r[13:11] | d0_r[5:3],
                          ctl_r[10], d0_r[1:0], ctl_r[7:0]} : wr_new;

    //////////////////////////////////////////////////////////////////////
    // Main control process
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            write_enable_latch_r <= 1'b0;
            ctl_r          <= `SR_RESET;
            nv_r           <= `SR_RESET;
            vol_r          <= 1'b0;
            fail_r         <= 1'b0;
            suspend_flag_r <= 1'b0;
            quad_r         <= 1'b0;
            rst_en_r       <= 1'b0;
            pe_busy_r      <= 1'b0;
            sh_r           <= 32'h0000_0000;
            cnt_r          <= 6'h00;
            op_r           <= 8'h00;
            d0_r           <= 8'h00;
            d1_r           <= 8'h00;
            so_r           <= 4'h0;
            tw_start       <= 1'b0;
            pe_start       <= 1'b0;
            pe_opcode      <= 8'h00;
            pe_addr        <= 24'h00_0000;
            pe_suspend     <= 1'b0;
            pe_resume      <= 1'b0;
            pe_abort       <= 1'b0;
        end else begin
            tw_start   <= 1'b0;
            pe_start   <= 1'b0;
            pe_suspend <= 1'b0;
            pe_resume  <= 1'b0;
            pe_abort   <= 1'b0;

            // Frame capture
            if (cs_fall) begin
                cnt_r <= 6'h00;
            end else if (sclk_rise) begin
                sh_r  <= sh_nxt;
                cnt_r <= cnt_nxt;
                if (cnt_nxt == `CNT_OP)
                    op_r <= sh_nxt[7:0];
                if (cnt_nxt == `CNT_D0)
                    d0_r <= sh_nxt[7:0];
                if (cnt_nxt == `CNT_D1)
                    d1_r <= sh_nxt[7:0];
                if (cnt_nxt == `CNT_ADDR)
                    pe_addr <= sh_nxt[23:0];
            end

            // read data on falling edge, MSB first
            if (sclk_fall && is_rd && cnt_r >= `CNT_OP) begin
                if (quad_r)
                    so_r <= cnt_r[2] ? rd_byte[3:0] : rd_byte[7:4];
                else
                    so_r <= {2'b00, rd_byte[~cnt_r[2:0]], 1'b0};
            end

            // Engine completion: clears latch and sets failure from result
            if (pe_done && pe_busy_r) begin
                pe_busy_r            <= 1'b0;
                fail_r               <= pe_fail;
                write_enable_latch_r <= 1'b0;
            end
            if (tw_done)
                write_enable_latch_r <= 1'b0;

            // Any frame other than a status read or volatile enable disarms it
            if (cs_rise && !is_rd)
                vol_r <= 1'b0;
            if (cs_rise)
                rst_en_r <= op_end && op_r == `OP_RST_EN;

            if (op_end && !busy_any) begin
                case (op_r)
                    `OP_LATCH_SET: write_enable_latch_r <= 1'b1;
                    `OP_VOL_WEN: begin
                        vol_r                <= 1'b1;
                        write_enable_latch_r <= 1'b0;
                    end
                    `OP_QUAD_ON:  quad_r <= 1'b1;
                    `OP_QUAD_OFF: quad_r <= 1'b0;
                    default: ;
                endcase
            end
            if (op_end && op_r == `OP_LATCH_CLR)
                write_enable_latch_r <= 1'b0;

            if (op_end && op_r == `OP_SUSPEND && pe_busy_r && !suspend_flag_r) begin
                suspend_flag_r <= 1'b1;
                pe_suspend     <= 1'b1;
            end
            if (op_end && op_r == `OP_RESUME && suspend_flag_r) begin
                suspend_flag_r <= 1'b0;
                pe_resume      <= 1'b1;
            end

            // volatile writes skip the timed cycle and keep lock bits
            // protect bits written only when unlocked
            if ((wr_sr || wr_cfg) && wr_ok) begin
                if (wr_sr)
                    ctl_r <= vol_r ? {wr_sel[15:14], ctl_r[13:11], wr_sel[10:0]} : wr_sel;
                if (vol_r) begin
                    write_enable_latch_r <= 1'b0;
                end else begin
                    if (wr_sr)
                        nv_r <= wr_sel;
                    tw_start <= 1'b1;
                end
            end

            // Program and erase launch
            if (pe_req && pe_ok) begin
                if (pe_prot) begin
                    fail_r               <= 1'b1;
                    write_enable_latch_r <= 1'b0;
                end else begin
                    pe_start  <= 1'b1;
                    pe_opcode <= op_r;
                    pe_busy_r <= 1'b1;
                end
            end

            // Soft or hard reset
            if (soft_rst) begin
                write_enable_latch_r <= 1'b0;
                vol_r                <= 1'b0;
                quad_r               <= 1'b0;
                suspend_flag_r       <= 1'b0;
                ctl_r <= (srp_mode == 2'b10) ?
                         {nv_r[15:9], 2'b10, nv_r[6:0]} : nv_r;
                if (pe_busy_r) begin
                    fail_r    <= 1'b1;
                    pe_busy_r <= 1'b0;
                    pe_abort  <= 1'b1;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Read byte and pin drive
    wire       rd_act  = ~cs_s && ~cs_fall && is_rd && cnt_r >= `CNT_OP;
    assign io_out = so_r;
    // Single line drives only IO1; four-line mode drives all
    assign io_oe  = rd_act ? (quad_r ? 4'hF : 4'h2) : 4'h0;
endmodule

// File: inc/flash_sr_defs.vh
// Opcodes, status bit positions and timing counts for the status/latch block
`ifndef FLASH_SR_DEFS_VH
`define FLASH_SR_DEFS_VH

// Command opcodes
`define OP_LATCH_SET   8'h06
`define OP_LATCH_CLR   8'h04
`define OP_VOL_WEN     8'h50
`define OP_RD_LO       8'h05
`define OP_RD_HI       8'h35
`define OP_WR_SR       8'h01
`define OP_WR_SRH      8'h31
`define OP_WR_CFG      8'h11
`define OP_PAGE_PROG   8'h02
`define OP_SECT_ERASE  8'h20
`define OP_HALF_ERASE  8'h52
`define OP_BLK_ERASE   8'hD8
`define OP_CHIP_ERASE0 8'h60
`define OP_CHIP_ERASE1 8'hC7
`define OP_SUSPEND     8'h75
`define OP_RESUME      8'h7A
`define OP_RST_EN      8'h66
`define OP_RST         8'h99
`define OP_QUAD_ON     8'h38
`define OP_QUAD_OFF    8'hFF

// Status word bit positions
`define SB_WIP   0
`define SB_WEL   1
`define SB_BP_LO 2
`define SB_BP_HI 6
`define SB_PROTECT_MODE_LOW  7
`define SB_PROTECT_MODE_HIGH  8
`define SB_QE    9
`define SB_FAIL  10
`define SB_LB1   11
`define SB_LB3   13
`define SB_CMP   14
`define SB_SUS   15
`define SR_RESET 16'h0000

// Frame bit counts at which fields complete
`define CNT_OP   6'd8
`define CNT_D0   6'd16
`define CNT_D1   6'd24
`define CNT_ADDR 6'd32
`define CNT_SAT  6'd63

// Security register select on address bits 15:10
`define SEC_SEL1 6'b000100
`define SEC_SEL2 6'b001000
`define SEC_SEL3 6'b001100

// Register write cycle time, plain default in microseconds
`define MCLK_MHZ 40
`define TW_US    5000
`define TW_CYCLES (`TW_US * `MCLK_MHZ)

`endif

// File: rtl/pin_sync.v
// Two-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module pin_sync #(
    parameter W       = 1,
    parameter RST_VAL = 0
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         resetn,
    // Pins in, synchronised out
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_r;
            reg hold_r;
            // First flop feeds only the second
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    meta_r <= RST_VAL[i];
                    hold_r <= RST_VAL[i];
                end else begin
                    meta_r <= d[i];
                    hold_r <= meta_r;
                end
            end
            assign q[i] = hold_r;
        end
    endgenerate
endmodule

// File: rtl/cycle_timer.v
// Self-timed busy counter for register write cycles
`timescale 1ns/1ps
module cycle_timer #(
    parameter CW = 18
) (
    // Clock and reset
    input  wire          mclk,
    input  wire          resetn,
    // Control
    input  wire          start,
    input  wire          abort,
    input  wire [CW-1:0] load,
    // Status
    output wire          busy,
    output reg           done
);
    reg [CW-1:0] cnt_r;

    // Countdown; done pulses once when it reaches zero
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= {CW{1'b0}};
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                cnt_r <= {CW{1'b0}};
            end else if (start) begin
                cnt_r <= load;
            end else if (cnt_r != {CW{1'b0}}) begin
                cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
                done  <= (cnt_r == {{(CW-1){1'b0}}, 1'b1});
            end
        end
    end
    assign busy = (cnt_r != {CW{1'b0}});
endmodule

// File: bench/flash_sr_asserts.sv
// Port-level checker for the flash status and write latch block
`timescale 1ns/1ps
`include "flash_sr_defs.vh"
module flash_sr_asserts #(
    parameter TW_CYCLES = 20
) (
    // Clock and reset
    input wire        mclk,
    input wire        resetn,
    // Pins and engine handshake
    input wire        cs_n_pin,
    input wire        pe_start,
    input wire [7:0]  pe_opcode,
    input wire        pe_suspend,
    input wire        pe_done,
    input wire        pe_fail,
    // Block state
    input wire [15:0] status_word,
    input wire        quad_pins_data
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // Latch and start ordering; cs sync delay leaves pin high two edges back
    property p_latch_frame;
        $rose(status_word[`SB_WEL]) |-> $past(cs_n_pin, 2);
    endproperty
    a_latch_frame: assert property (p_latch_frame) else $error("latch set mid-frame");
    property p_start_latch;
        pe_start |-> $past(status_word[`SB_WEL]);
    endproperty
    a_start_latch: assert property (p_start_latch) else $error("start without latch");
    property p_done_latch;
        pe_done && status_word[`SB_WIP] |-> ##[1:2] !status_word[`SB_WEL];
    endproperty
    a_done_latch: assert property (p_done_latch) else $error("latch kept after op");
    property p_chip;
        pe_start && (pe_opcode == `OP_CHIP_ERASE0 || pe_opcode == `OP_CHIP_ERASE1)
            |-> $past(status_word[6:2]) == 5'h00 && !$past(status_word[`SB_CMP]);
    endproperty
    a_chip: assert property (p_chip) else $error("chip erase while protected");

    ////////////////////////////////////////////////////////////////////////
    // Status bit behaviour
    property p_mode10;
        status_word[8:7] == 2'b10 |=> status_word[8:7] == 2'b10;
    endproperty
    a_mode10: assert property (p_mode10) else $error("mode 10 left early");
    property p_qe;
        quad_pins_data == status_word[`SB_QE];
    endproperty
    a_qe: assert property (p_qe) else $error("quad pin use differs");
    property p_fail;
        pe_done && pe_fail && status_word[`SB_WIP] |=> status_word[`SB_FAIL];
    endproperty
    a_fail: assert property (p_fail) else $error("failure flag not set");
    property p_lock;
        ($past(status_word[13:11]) & ~status_word[13:11]) == 3'b000;
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit cleared");
    property p_susp;
        pe_suspend |-> ##[0:1] status_word[`SB_SUS];
    endproperty
    a_susp: assert property (p_susp) else $error("suspend flag missing");

    // Main scenarios reached
    c_start: cover property (pe_start);
    c_susp: cover property ($rose(status_word[`SB_SUS]));
    c_mode10: cover property (status_word[8:7] == 2'b10);
endmodule

bind flash_status_write_latch flash_sr_asserts #(.TW_CYCLES(TW_CYCLES)) u_chk (
    .mclk(mclk), .resetn(resetn), .cs_n_pin(cs_n_pin), .pe_start(pe_start),
    .pe_opcode(pe_opcode), .pe_suspend(pe_suspend), .pe_done(pe_done),
    .pe_fail(pe_fail), .status_word(status_word), .quad_pins_data(quad_pins_data)
);

// File: bench/host_model.sv
// Host controller model: chip select, serial clock and four data lines
`timescale 1ns/1ps
module host_model (
    // Write-protect level for IO2
    input  wire       wp,
    // Resolved data lines
    input  wire [3:0] io_wire,
    // Host pins
    output reg        cs_n,
    output reg        sclk,
    output reg  [3:0] io_drv
);
    ////////////////////////////////////////////////////////////////////////
    // Idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_drv = 4'hB;
    end
    // One frame: nb bits out MSB first, then nr clocks of read-back
    task xfer(input [31:0] d, input integer nb, input integer q,
              input integer nr, output [7:0] r);
        integer k;
        begin
            r = 8'h00;
            cs_n = 1'b0;
            // nibble per edge in four-line mode, IO3 on top
            for (k = nb; k > 0; k = k - (q ? 4 : 1)) begin
                io_drv = q ? d[k-1 -: 4] : {1'b1, wp, ~io_drv[1], d[k-1]};
                #100 sclk = 1'b1;
                #100 sclk = 1'b0;
            end
            // Released input toggles so a stale level never reads as data
            for (k = 0; k < nr; k = k + 1) begin
                io_drv[0] = ~io_drv[0];
                #100 sclk = 1'b1;
                #100 r = q ? {r[3:0], io_wire} : {r[6:0], io_wire[1]};
                sclk = 1'b0;
            end
            #100 cs_n = 1'b1;
            #250;
        end
    endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench of the flash status and write latch block
`timescale 1ns/1ps
`include "flash_sr_defs.vh"
module testbench;
    reg         mclk = 1'b0;
    reg         resetn = 1'b0;
    reg         hard_reset_n_pin = 1'b1;
    reg         wp = 1'b1;
    reg         pe_done = 1'b0;
    reg         pe_fail = 1'b0;
    reg         target_protected = 1'b0;
    reg         q = 1'b0;
    integer     n_starts = 0;
    integer     n_mark = 0;
    wire        started = (n_starts != n_mark);
    reg  [7:0]  rd;
    reg  [7:0]  b1;
    reg  [7:0]  b2;
    reg  [23:0] a;
    reg  [15:0] exp;
    integer     i;
    integer     n_errors = 0;
    integer     total_checks = 0;
    wire        cs_n;
    wire        sclk;
    wire [3:0]  io_drv;
    wire [3:0]  io_out;
    wire [3:0]  io_oe;
    wire        pe_start;
    wire [7:0]  pe_opcode;
    wire [23:0] pe_addr;
    wire [15:0] sw;
    wire        qpd;
    wire        flm;
    // Device drives where enabled, host elsewhere
    wire [3:0]  io_in = (io_oe & io_out) | (~io_oe & io_drv);

    flash_status_write_latch #(.TW_CYCLES(400)) i_flash_status_write_latch (
        .mclk(mclk), .resetn(resetn), .cs_n_pin(cs_n), .sclk_pin(sclk),
        .hard_reset_n_pin(hard_reset_n_pin), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .pe_start(pe_start), .pe_opcode(pe_opcode), .pe_addr(pe_addr),
        .pe_suspend(), .pe_resume(), .pe_abort(), .pe_done(pe_done), .pe_fail(pe_fail),
        .target_protected(target_protected), .status_word(sw),
        .quad_pins_data(qpd), .four_line_mode(flm)
    );
    host_model i_host_model (.wp(wp), .io_wire(io_in), .cs_n(cs_n), .sclk(sclk),
        .io_drv(io_drv));

    ////////////////////////////////////////////////////////////////////////
    // Clock and start watcher
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) if (pe_start) n_starts <= n_starts + 1;

    task check(input [31:0] seen, input [31:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: got %h want %h", $time, seen, want);
            end
        end
    endtask
    task cmd(input [31:0] d, input integer nb);
        i_host_model.xfer(d, nb, q, 0, rd);
    endtask
    task status_read_cmd(input [7:0] op);
        i_host_model.xfer({24'h000000, op}, 8, q, q ? 2 : 8, rd);
    endtask
    task soft_rst;
        begin
            cmd(`OP_RST_EN, 8);
            cmd(`OP_RST, 8);
        end
    endtask
    // Bounded wait for the busy bit to drop
    task wait_idle;
        integer k;
        begin
            for (k = 0; k < 1000 && sw[`SB_WIP] !== 1'b0; k = k + 1)
                @(posedge mclk);
            // A hung busy bit counts as a mismatch
            if (k == 1000)
                n_errors = n_errors + 1;
            // Latch drops one edge after busy; settle off the edge
            repeat (2) @(negedge mclk);
        end
    endtask
    task finish_pe(input f);
        begin
            @(negedge mclk);
            pe_fail = f;
            pe_done = 1'b1;
            @(negedge mclk);
            pe_done = 1'b0;
            repeat (3) @(negedge mclk);
        end
    endtask
    // Status after a finished write of bytes x and y; locks only accumulate
    function [15:0] sr_after(input [15:0] o, input [7:0] x, input [7:0] y);
        sr_after = {o[15], y[6], o[13:11] | y[5:3], o[10], y[1:0], x[7:2], 2'b00};
    endfunction
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rd = $urandom(72740);
        repeat (2) @(posedge mclk);
        @(negedge mclk) resetn = 1'b1;
        repeat (4) @(negedge mclk);
        check(sw, `SR_RESET);
        cmd({`OP_LATCH_SET, 1'b0}, 9);
        check(sw, 16'h0000);
        cmd(`OP_LATCH_SET, 8);
        status_read_cmd(`OP_RD_LO);
        check(rd, 8'h02);
        cmd(`OP_LATCH_CLR, 8);
        check(sw, 16'h0000);
        cmd({`OP_WR_SR, 8'h7C, 8'h02}, 24);
        check(sw, 16'h0000);
        // Random timed writes, polled while busy
        for (i = 0; i < 3; i = i + 1) begin
            b1 = $urandom & 8'h7C;
            b2 = $urandom & 8'h7A;
            exp = sr_after(sw, b1, b2);
            cmd(`OP_LATCH_SET, 8);
            cmd({`OP_WR_SR, b1, b2}, 24);
            status_read_cmd(`OP_RD_LO);
            check(rd[1:0], 2'b11);
            wait_idle;
            check(sw, exp);
            check(qpd, exp[`SB_QE]);
            status_read_cmd(`OP_RD_HI);
            check(rd, exp[15:8]);
        end
        // volatile arm straight before each write, into mode 01 and then mode 10
        @(negedge mclk) wp = 1'b0;
        exp = sr_after(sw, 8'h80, 8'h00);
        cmd(`OP_VOL_WEN, 8);
        check(sw[`SB_WEL], 1'b0);
        cmd({`OP_WR_SR, 8'h80, 8'h00}, 24);
        check(sw, exp);
        cmd(`OP_VOL_WEN, 8);
        cmd({`OP_WR_SR, 8'h00, 8'h00}, 24);
        check(sw, exp);
        @(negedge mclk) wp = 1'b1;
        cmd(`OP_VOL_WEN, 8);
        cmd({`OP_WR_SR, 8'h00, 8'h09}, 24);
        exp = sr_after(exp, 8'h00, 8'h01);
        check(sw, exp);
        soft_rst;
        check(sw[8:7], 2'b10);
        cmd(`OP_LATCH_SET, 8);
        cmd({`OP_WR_SR, 8'h00, 8'h00}, 24);
        wait_idle;
        check(sw[8:7], 2'b10);
        @(negedge mclk) hard_reset_n_pin = 1'b0;
        repeat (4) @(negedge mclk);
        hard_reset_n_pin = 1'b1;
        check(sw[8:7], 2'b10);
        resetn = 1'b0;
        @(negedge mclk) resetn = 1'b1;
        repeat (4) @(negedge mclk);
        check(sw, 16'h0000);
        // Program: refused, suspended, cut by reset, failed, passed
        n_mark = n_starts;
        cmd({`OP_PAGE_PROG, 24'h012340}, 32);
        check(started, 1'b0);
        cmd(`OP_LATCH_SET, 8);
        cmd({`OP_PAGE_PROG, 24'h012340}, 32);
        cmd(`OP_SUSPEND, 8);
        check(sw[`SB_SUS], 1'b1);
        cmd(`OP_RESUME, 8);
        check(sw[`SB_SUS], 1'b0);
        cmd(`OP_SUSPEND, 8);
        soft_rst;
        check({sw[15], sw[10], sw[0]}, 3'b010);
        for (i = 0; i < 2; i = i + 1) begin
            a = $urandom;
            n_mark = n_starts;
            cmd(`OP_LATCH_SET, 8);
            cmd({`OP_PAGE_PROG, a}, 32);
            check({started, sw[1:0], pe_addr}, {3'b111, a});
            finish_pe(i == 0);
            check({sw[10], sw[1:0]}, {i == 0, 2'b00});
        end
        @(negedge mclk) target_protected = 1'b1;
        n_mark = n_starts;
        cmd(`OP_LATCH_SET, 8);
        cmd({`OP_SECT_ERASE, a}, 32);
        check({started, sw[10], sw[1]}, 3'b010);
        @(negedge mclk) target_protected = 1'b0;
        // Chip erase with protect bits set, then cleared
        for (i = 0; i < 2; i = i + 1) begin
            cmd(`OP_LATCH_SET, 8);
            cmd({`OP_WR_SR, i ? 8'h00 : 8'h10}, 16);
            wait_idle;
            n_mark = n_starts;
            cmd(`OP_LATCH_SET, 8);
            cmd(i ? `OP_CHIP_ERASE1 : `OP_CHIP_ERASE0, 8);
            check(started, i);
        end
        finish_pe(1'b0);
        // Four-line mode, commands and read-back by nibbles
        cmd(`OP_QUAD_ON, 8);
        q = 1'b1;
        check(flm, 1'b1);
        cmd(`OP_LATCH_SET, 8);
        status_read_cmd(`OP_RD_LO);
        check(rd, 8'h02);
        cmd(`OP_QUAD_OFF, 8);
        q = 1'b0;
        check(flm, 1'b0);
        tally_and_finish;
    end

    // Watchdog far beyond the expected run of a few hundred microseconds
    initial begin
        #2000000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end
endmodule
